/* macrocell_logic_array_test.sv */
/* Self-checking bench for mla_top with the host model.
   Assumes package, mla_top and mla_host compile first. */
`default_nettype none
module macrocell_logic_array_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk, arst_n, level_load, host_address_strobe, wr_strobe;
    logic dedicated_clock_input, b;
    logic [1:0] sel_in_port;
    logic [2:0] cs_terms, ext_cs;
    logic [3:0] sel, s;
    logic [5:0] in_gate_terms, cfg_in_gate_sel;
    logic [7:0] host_wdata, host_rdata;
    logic [15:0] pt_clock, pt_preset, cfg_polarity, cfg_clk_sel, cells;
    logic [15:0] cfg_comb_sel, cfg_pt_lend, cfg_pt_borrow, cell_out;
    logic [15:0] cell_feedback;
    logic [23:0] pin_in, pin_dir, pt_oe, no_oe_eqn, pin_oe, in_bus, x, y;
    logic [31:0] pt_clear, cfg_ff_type;
    logic [47:0] cfg_in_mode;
    logic [79:0] ab_terms, bc_terms, ab_k_terms, bc_k_terms;
    logic [26:0] exp_q[$]; // Output code and expected value
    logic [26:0] e;
    int fails, n_compared, cyc, seed, j;
    event look;
    mla_host i_mla_host (.clk, .wdata(host_wdata), .wr(wr_strobe), .sel);
    mla_top i_mla_top (.clk, .arst_n, .host_wdata, .wr_strobe,
        .sel_ab_cells(sel[0]), .sel_bc_cells(sel[1]), .sel_ab_mask(sel[2]),
        .sel_bc_mask(sel[3]), .sel_in_port, .level_load, .host_address_strobe,
        .host_rdata, .ab_terms, .bc_terms, .ab_k_terms, .bc_k_terms,
        .pt_clock, .pt_preset, .pt_clear, .cs_terms, .in_gate_terms,
        .dedicated_clock_input, .cfg_polarity, .cfg_ff_type, .cfg_clk_sel,
        .cfg_comb_sel, .cfg_pt_lend, .cfg_pt_borrow, .cfg_in_mode,
        .cfg_in_gate_sel, .pin_in, .pin_dir, .pt_oe, .no_oe_eqn, .cell_out,
        .cell_feedback, .pin_oe, .in_bus, .ext_cs);
    always #5 clk = ~clk;
    task automatic check(input logic [23:0] got, input logic [23:0] want);
        n_compared++;
        if (got !== want) begin
            fails++;
            $display("unexpected at %0t: got %h want %h", $time, got, want);
        end
    endtask
    task automatic note(input logic [2:0] c, input logic [23:0] v);
        exp_q.push_back({c, v});
        -> look;
        #0; // Monitor takes this note before the next one
    endtask
    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Monitor: oldest note against the output it names
    always @(look) begin
        e = exp_q.pop_front();
        case (e[26:24])
            3'h0: check({16'h0000, host_rdata}, e[23:0]);
            3'h1: check({8'h00, cell_out}, e[23:0]);
            3'h2: check(pin_oe, e[23:0]);
            3'h4: check(in_bus, e[23:0]);
            default: check({5'h00, ext_cs, cell_feedback}, e[23:0]);
        endcase
    end
    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            fails++;
            final_report();
        end
    end
    initial begin
        seed = 87;
        clk = 1'b0;
        arst_n = 1'b0;
        cells = 16'h0000;
        sel_in_port = 2'h3;
        {level_load, host_address_strobe, dedicated_clock_input, cs_terms,
         in_gate_terms, cfg_in_gate_sel, pt_clock, pt_preset, cfg_polarity,
         cfg_clk_sel, cfg_comb_sel, cfg_pt_lend, cfg_pt_borrow, pin_in,
         pin_dir, pt_oe, no_oe_eqn, pt_clear, cfg_ff_type, cfg_in_mode,
         ab_terms, bc_terms, ab_k_terms, bc_k_terms} = '0;
        repeat (8) @(posedge clk);
        #1 arst_n = 1'b1;
        // Per group: reset mask, load, masked load, read-back
        for (int g = 0; g < 2; g++) begin
            s = g ? 4'h2 : 4'h1;
            level_load = g[0];
            x = 24'($random(seed));
            i_mla_host.read(s << 2);
            note(0, 24'h000000);
            i_mla_host.write(s, x[7:0]);
            i_mla_host.write(s << 2, 8'h0F);
            i_mla_host.write(s, ~x[7:0]);
            i_mla_host.read(s << 2);
            note(0, 24'h00000F);
            i_mla_host.read(s);
            cells[g*8+:8] = {~x[7:4], x[3:0]};
            note(0, {16'h0000, cells[g*8+:8]});
            note(1, {8'h00, cells});
            i_mla_host.write(s << 2, 8'h00);
        end
        // Combinational sums, polarity, enables, chip selects
        cfg_comb_sel = 16'hFFFF;
        {cfg_in_gate_sel, sel_in_port, y} = {6'h3F, 26'h0};
        cfg_in_mode = {{12{2'h2}}, {12{2'h1}}};
        for (int n = 0; n < 4; n++) begin
            cfg_polarity = 16'($random(seed));
            {cfg_pt_borrow, cfg_pt_lend} = 32'($random(seed));
            pin_in = 24'($random(seed));
            host_address_strobe = n[0];
            y = n[0] ? pin_in : y;
            cs_terms = 3'($random(seed));
            {pin_dir, pt_oe} = 48'({$random(seed), $random(seed)});
            no_oe_eqn = 24'($random(seed) & $random(seed));
            for (int i = 0; i < 8; i++) begin
                j = (i == 7) ? 6 : i + 1;
                ab_terms[i*10+:10] = 10'($random(seed) & $random(seed));
                bc_terms[i*10+:10] = 10'($random(seed) & $random(seed));
                b = cfg_pt_borrow[i] & cfg_pt_lend[j] & ~cfg_pt_borrow[j];
                x[i] = (|(ab_terms[i*10+:10] & (b ? 10'h1FF : 10'h007)))
                    ^ cfg_polarity[i];
                b = cfg_pt_borrow[8+i] & cfg_pt_lend[8+j] &
                    ~cfg_pt_borrow[8+j];
                x[8+i] = (|(bc_terms[i*10+:10] & (!b ? 10'h00F : i < 4 ?
                    10'h1FF : 10'h3FF))) ^ cfg_polarity[8+i];
            end
            @(posedge clk) #1;
            note(1, {8'h00, x[15:0]});
            note(3, {5'h00, cs_terms, x[15:0]});
            note(2, pt_oe | pin_dir | no_oe_eqn);
            note(4, y);
            note(0, {16'h0000, y[7:0]});
        end
        final_report();
    end
endmodule
`default_nettype wire

/* mla_defines.svh */
/*
 * Constants for the macrocell logic array: cell counts, flip-flop
 * type codes, input cell modes and reset values.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef MLA_DEFINES_SVH
`define MLA_DEFINES_SVH

// ----------------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------------
`define MLA_GROUP_CELLS 8
`define MLA_AB_NATIVE 3
`define MLA_AB_BORROW 6
`define MLA_BC_NATIVE 4
`define MLA_BC_BORROW_LO 5
`define MLA_BC_BORROW_HI 6
`define MLA_PT_MAX 10
`define MLA_EXT_CS 3
`define MLA_IN_CELLS 24
`define MLA_BC_SPLIT 4

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define MLA_MASK_RESET 8'h00
`define MLA_ZERO8 8'h00

// ----------------------------------------------------------------------
// Flip-flop type codes
// ----------------------------------------------------------------------
`define MLA_FF_D 2'h0
`define MLA_FF_T 2'h1
`define MLA_FF_JK 2'h2
`define MLA_FF_SR 2'h3

// ----------------------------------------------------------------------
// Input cell mode codes
// ----------------------------------------------------------------------
`define MLA_IN_PASS 2'h0
`define MLA_IN_LATCH 2'h1
`define MLA_IN_REG 2'h2

`endif

/* mla_host.sv */
/* Host model for the macrocell logic array: drives data bus and selects.
   Assumes the bench supplies the 100 MHz clock. */
`default_nettype none
module mla_host (
    input wire logic clk, // System clock
    output logic [7:0] wdata, // Internal data bus
    output logic wr, // Write strobe
    output logic [3:0] sel // AB cells, BC cells, AB mask, BC mask
);
    timeunit 1ns;
    timeprecision 100ps;
    // Idle bus at time zero
    initial begin
        wdata = 8'h00;
        wr = 1'b0;
        sel = 4'h0;
    end
    // Write: strobe one cycle, held select, then release
    task automatic write(input logic [3:0] s, input logic [7:0] d);
        @(posedge clk) #1;
        sel = s;
        wr = 1'b1;
        wdata = d;
        @(posedge clk) #1;
        wr = 1'b0;
        @(posedge clk) #1;
        sel = 4'h0;
        wdata = ~d; // Released bus shows no stale value
    endtask
    // Read: select held until the registered data has settled
    task automatic read(input logic [3:0] s);
        @(posedge clk) #1;
        sel = s;
        repeat (2) @(posedge clk);
        #1;
    endtask
endmodule
`default_nettype wire

/* mla_out_cell.sv */
/*
 * One output macrocell: sum of product terms, polarity XOR,
 * configurable flip-flop, host load, registered or combinational select.
 * Assumes pt is already masked by the allocator above; pt_k arrives unmasked.
 */
`default_nettype none
`include "mla_defines.svh"

module mla_out_cell #(
    parameter int NPT = `MLA_PT_MAX
) (
    input wire logic clk,             // System clock
    input wire logic arst_n,          // Async reset, active low
    input wire logic [NPT-1:0] pt,    // Usable product terms
    input wire logic [NPT-1:0] pt_k,  // Second terms for K or R input
    input wire logic polarity,        // Invert sum when high
    input wire logic [1:0] ff_type,   // D, T, JK or SR
    input wire logic clk_en,          // Flip-flop clock edge enable
    input wire logic preset,          // Active high preset
    input wire logic clear,           // Active high clear
    input wire logic load,            // Host load strobe
    input wire logic load_data,       // Host data bit
    input wire logic comb_sel,        // Select combinational output
    output logic out,                 // Selected cell output
    output logic q                    // Flip-flop state
);
    typedef struct packed {
        logic q;
    } mla_cell_state_type;

    mla_cell_state_type state_reg;    // Registered state
    mla_cell_state_type state_next;   // Next state
    logic sum;                        // Polarity corrected sum
    logic sum_k;                      // Second input sum

    // ------------------------------------------------------------------
    // Combinational path and next state
    // ------------------------------------------------------------------
    always_comb begin
        sum = (|pt) ^ polarity;              // see RQ7
        sum_k = |pt_k;
        state_next = state_reg;
        if (load) begin
            state_next.q = load_data;        // see RQ12
        end else if (clear) begin
            state_next.q = 1'b0;             // see RQ11
        end else if (preset) begin
            state_next.q = 1'b1;             // see RQ11
        end else if (clk_en) begin
            unique case (ff_type)            // see RQ9
                `MLA_FF_D: state_next.q = sum;
                `MLA_FF_T: state_next.q = state_reg.q ^ sum;
                `MLA_FF_JK: state_next.q = (sum & ~state_reg.q) |
                                           (~sum_k & state_reg.q);
                `MLA_FF_SR: state_next.q = sum | (~sum_k & state_reg.q);
            endcase
        end
    end

    // State register
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign q = state_reg.q;
    assign out = comb_sel ? sum : state_reg.q;   // see RQ8

    // Host load wins over the clock path
    property p_load_wins;
        @(posedge clk) disable iff (!arst_n)
        load |=> (q == $past(load_data));
    endproperty
    a_load_wins: assert property (p_load_wins) // see RQ12
        else $error("host load did not win");

    // Clear without load drives zero
    property p_clear;
        @(posedge clk) disable iff (!arst_n)
        (clear && !load) |=> !q;
    endproperty
    a_clear: assert property (p_clear) // see RQ11
        else $error("clear did not zero flip-flop");

    // Combinational select follows the polarity sum
    property p_comb;
        @(posedge clk) disable iff (!arst_n)
        comb_sel |-> (out == ((|pt) ^ polarity));
    endproperty
    a_comb: assert property (p_comb) // see RQ7
        else $error("combinational output wrong");
endmodule

`default_nettype wire

/* mla_pkg.sv */
/*
 * Types shared by the macrocell logic array files.
 * Assumes mla_defines.svh is on the include path.
 */
`default_nettype none
`include "mla_defines.svh"

package mla_pkg;
    // Per group byte
    typedef logic [`MLA_GROUP_CELLS-1:0] mla_byte_type;
    // Host load tracker states
    typedef enum logic [0:0] {MLA_IDLE, MLA_WRITING} mla_load_type;
endpackage

`default_nettype wire

/* mla_top.sv */
/*
 * Macrocell logic array: sixteen output cells with product term
 * borrowing, host load with write masks, pin output enables and
 * twenty-four input cells with latch, register or pass modes.
 * Assumes the AND array, address decode and bus timing sit outside;
 * product terms arrive as synchronous inputs on clk.
 */
`default_nettype none
`include "mla_defines.svh"

// Summary of operation
// RQ1 - Three port D chip selects, no cells used
// RQ2 - Sixteen output cells in two groups
// RQ3 - First group: three native, six borrowed
// RQ4 - Second group 0-3: four native, five borrowed
// RQ5 - Second group 4-7: four native, six borrowed
// RQ6 - Used terms never lent; neighbours only
// RQ7 - Sum passes polarity XOR stage
// RQ8 - Register or combinational select drives pin, feedback
// RQ9 - Flip-flop is D, T, JK or SR
// RQ10 - Clock from product term or dedicated input
// RQ11 - Active high preset, two-term clear
// RQ12 - Host load beats clock, preset, clear
// RQ13 - Cell n uses data bit n
// RQ14 - Edge or level host loading
// RQ15 - Eight-bit write masks reset zero, block writes
// RQ16 - Host reads input and output cells
// RQ17 - Pin enable is term OR direction bit
// RQ18 - Output without enable equation driven from reset
// RQ19 - 24 input cells: latch, register, pass
// RQ20 - Input cell gate from term or strobe
// RQ21 - One term per four input cells
// RQ22 - Strobe captures high address bits as inputs
// RQ23 - Masked cell keeps normal behaviour
module mla_top (
    input wire logic clk,                       // System clock 100 MHz
    input wire logic arst_n,                    // Async reset, active low
    // Host side
    input wire logic [7:0] host_wdata,          // Internal data bus in
    input wire logic wr_strobe,                 // Host write strobe
    input wire logic sel_ab_cells,              // Access first group cells
    input wire logic sel_bc_cells,              // Access second group cells
    input wire logic sel_ab_mask,               // Access first group mask
    input wire logic sel_bc_mask,               // Access second group mask
    input wire logic [1:0] sel_in_port,         // Input cell port read select
    input wire logic level_load,                // Level rather than edge load
    input wire logic host_address_strobe,       // Host address strobe
    output logic [7:0] host_rdata,              // Internal data bus out
    // AND array side
    input wire logic [79:0] ab_terms,           // Group AB terms, 10 per cell
    input wire logic [79:0] bc_terms,           // Group BC terms, 10 per cell
    input wire logic [79:0] ab_k_terms,         // Group AB second terms
    input wire logic [79:0] bc_k_terms,         // Group BC second terms
    input wire logic [15:0] pt_clock,           // Per cell clock terms
    input wire logic [15:0] pt_preset,          // Per cell preset terms
    input wire logic [31:0] pt_clear,           // Two clear terms per cell
    input wire logic [2:0] cs_terms,            // Chip select terms
    input wire logic [5:0] in_gate_terms,       // Input cell gate terms
    input wire logic dedicated_clock_input,     // Dedicated clock pin level
    // Configuration
    input wire logic [15:0] cfg_polarity,       // Output polarity per cell
    input wire logic [31:0] cfg_ff_type,        // Flip-flop type per cell
    input wire logic [15:0] cfg_clk_sel,        // High: dedicated clock
    input wire logic [15:0] cfg_comb_sel,       // High: combinational
    input wire logic [15:0] cfg_pt_lend,        // Cell lends spare terms
    input wire logic [15:0] cfg_pt_borrow,      // Cell borrows from neighbour
    input wire logic [47:0] cfg_in_mode,        // Input cell mode, 2 bits each
    input wire logic [5:0] cfg_in_gate_sel,     // High: address strobe gate
    // Port pins
    input wire logic [23:0] pin_in,             // Ports A, B, C pin levels
    input wire logic [23:0] pin_dir,            // Direction register bits
    input wire logic [23:0] pt_oe,              // Output enable terms
    input wire logic [23:0] no_oe_eqn,          // Pin has no enable equation
    output logic [15:0] cell_out,               // Cell outputs to pins
    output logic [15:0] cell_feedback,          // Cell feedback to array
    output logic [23:0] pin_oe,                 // Pin driver enables
    output logic [23:0] in_bus,                 // Input cell bus to array
    output logic [2:0] ext_cs                   // Port D chip selects
);
    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] ab_mask;                  // First group write mask
        logic [7:0] bc_mask;                  // Second group write mask
        logic [23:0] in_reg;                  // Input cell storage
        logic [5:0] gate_d;                   // Gate sampled last cycle
        logic [15:0] clk_d;                   // Cell clock last cycle
        logic wr_d;                           // Write strobe last cycle
        logic [7:0] rdata;                    // Read data register
        mla_pkg::mla_load_type load_st;       // Host write tracker
    } mla_state_type;

    mla_state_type state_reg;                 // Registered state
    mla_state_type state_next;                // Next state
    logic [15:0] cell_clk;                    // Selected cell clocks
    logic [15:0] cell_q;                      // Flip-flop contents
    logic [15:0] load_vec;                    // Per cell load strobe
    logic [15:0] write_hit;                   // Unmasked write per cell
    logic [159:0] terms;                      // All cell terms
    logic [159:0] k_terms;                    // All second terms
    logic [159:0] use_terms;                  // Allocated terms
    logic [5:0] gate;                         // Input cell gates
    logic [23:0] in_gate_vec;                 // Gate per input cell
    logic wr_end;                             // Trailing write edge

    assign terms = {bc_terms, ab_terms};
    assign k_terms = {bc_k_terms, ab_k_terms};

    // Native plus borrow count per cell index
    function automatic int mla_pt_limit(input int idx);
        if (idx < `MLA_GROUP_CELLS) begin
            return `MLA_AB_NATIVE + `MLA_AB_BORROW;          // see RQ3
        end else if (idx < `MLA_GROUP_CELLS + `MLA_BC_SPLIT) begin
            return `MLA_BC_NATIVE + `MLA_BC_BORROW_LO;       // see RQ4
        end else begin
            return `MLA_BC_NATIVE + `MLA_BC_BORROW_HI;       // see RQ5
        end
    endfunction

    // Native term count per cell index
    function automatic int mla_pt_native(input int idx);
        if (idx < `MLA_GROUP_CELLS) begin
            return `MLA_AB_NATIVE;
        end else begin
            return `MLA_BC_NATIVE;
        end
    endfunction

    // ------------------------------------------------------------------
    // Product term allocator and output cells
    // ------------------------------------------------------------------
    genvar gi;
    genvar gj;
    generate
        for (gi = 0; gi < 16; gi++) begin : g_cell // see RQ2
            // Neighbour within group that may lend to this cell
            localparam int NB = (gi % `MLA_GROUP_CELLS == 7) ? gi - 1 : gi + 1;
            for (gj = 0; gj < `MLA_PT_MAX; gj++) begin : g_pt
                // Native terms always; borrowed terms only when the
                // neighbour lends and is not itself borrowing
                if (gj < mla_pt_native(gi)) begin : g_nat
                    assign use_terms[gi*10+gj] = terms[gi*10+gj];
                end else if (gj < mla_pt_limit(gi)) begin : g_bor
                    assign use_terms[gi*10+gj] = terms[gi*10+gj] &
                        cfg_pt_borrow[gi] & cfg_pt_lend[NB] &
                        ~cfg_pt_borrow[NB];            // see RQ6
                end else begin : g_none
                    assign use_terms[gi*10+gj] = 1'b0;
                end
            end

            // Clock from term or dedicated input
            assign cell_clk[gi] = cfg_clk_sel[gi] ? dedicated_clock_input
                                                  : pt_clock[gi]; // see RQ10

            mla_out_cell #(.NPT(`MLA_PT_MAX)) u_cell (
                .clk(clk),
                .arst_n(arst_n),
                .pt(use_terms[gi*10 +: 10]),
                .pt_k(k_terms[gi*10 +: 10]),
                .polarity(cfg_polarity[gi]),
                .ff_type(cfg_ff_type[gi*2 +: 2]),
                .clk_en(cell_clk[gi] & ~state_reg.clk_d[gi]), // see RQ10
                .preset(pt_preset[gi]),
                .clear(|pt_clear[gi*2 +: 2]),                 // see RQ11
                .load(load_vec[gi]),
                .load_data(host_wdata[gi % 8]),               // see RQ13
                .comb_sel(cfg_comb_sel[gi]),
                .out(cell_out[gi]),
                .q(cell_q[gi])
            );
        end
    endgenerate

    assign cell_feedback = cell_out;                          // see RQ8

    // ------------------------------------------------------------------
    // Host load with masks
    // ------------------------------------------------------------------
    assign wr_end = state_reg.wr_d & ~wr_strobe;
    assign write_hit = {{8{sel_bc_cells}} & ~state_reg.bc_mask,
                        {8{sel_ab_cells}} & ~state_reg.ab_mask}; // see RQ15
    // Masked cells get no load and run normally; see RQ23
    assign load_vec = write_hit & {16{level_load ? wr_strobe
                                                 : wr_end}}; // see RQ14

    // ------------------------------------------------------------------
    // Input cells
    // ------------------------------------------------------------------
    genvar gk;
    generate
        for (gk = 0; gk < 6; gk++) begin : g_gate
            assign gate[gk] = cfg_in_gate_sel[gk] ? host_address_strobe
                                                  : in_gate_terms[gk]; // see RQ20
        end
        for (gk = 0; gk < `MLA_IN_CELLS; gk++) begin : g_in
            assign in_gate_vec[gk] = gate[gk / `MLA_BC_SPLIT];  // see RQ21
            always_comb begin
                unique case (cfg_in_mode[gk*2 +: 2])            // see RQ19
                    `MLA_IN_LATCH: in_bus[gk] = in_gate_vec[gk] ?
                                   pin_in[gk] : state_reg.in_reg[gk];
                    `MLA_IN_REG: in_bus[gk] = state_reg.in_reg[gk];
                    default: in_bus[gk] = pin_in[gk];
                endcase
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Pins and chip selects
    // ------------------------------------------------------------------
    assign pin_oe = pt_oe | pin_dir | no_oe_eqn;          // see RQ17 RQ18
    assign ext_cs = cs_terms;                             // see RQ1
    assign host_rdata = state_reg.rdata;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        state_next.wr_d = wr_strobe;
        state_next.clk_d = cell_clk;
        state_next.gate_d = gate;
        unique case (state_reg.load_st)
            mla_pkg::MLA_IDLE: begin
                if (wr_strobe) begin
                    state_next.load_st = mla_pkg::MLA_WRITING;
                end
            end
            mla_pkg::MLA_WRITING: begin
                if (!wr_strobe) begin
                    state_next.load_st = mla_pkg::MLA_IDLE;
                end
            end
        endcase
        // Mask writes on the trailing edge
        if (wr_end && sel_ab_mask) begin
            state_next.ab_mask = host_wdata;                  // see RQ15
        end
        if (wr_end && sel_bc_mask) begin
            state_next.bc_mask = host_wdata;                  // see RQ15
        end
        // Input cell capture; strobe gate captures high address bits
        for (int i = 0; i < `MLA_IN_CELLS; i++) begin
            if (cfg_in_mode[i*2 +: 2] == `MLA_IN_LATCH &&
                in_gate_vec[i]) begin
                state_next.in_reg[i] = pin_in[i];             // see RQ22
            end else if (cfg_in_mode[i*2 +: 2] == `MLA_IN_REG &&
                         in_gate_vec[i] &&
                         !state_reg.gate_d[i / `MLA_BC_SPLIT]) begin
                state_next.in_reg[i] = pin_in[i];             // see RQ22
            end
        end
        // Read mux
        if (sel_ab_cells) begin
            state_next.rdata = cell_q[7:0];                   // see RQ16
        end else if (sel_bc_cells) begin
            state_next.rdata = cell_q[15:8];                  // see RQ16
        end else if (sel_ab_mask) begin
            state_next.rdata = state_reg.ab_mask;
        end else if (sel_bc_mask) begin
            state_next.rdata = state_reg.bc_mask;
        end else begin
            unique case (sel_in_port)
                2'h0: state_next.rdata = in_bus[7:0];
                2'h1: state_next.rdata = in_bus[15:8];
                2'h2: state_next.rdata = in_bus[23:16];
                default: state_next.rdata = `MLA_ZERO8;
            endcase
        end
    end

    // State register
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= '0;
            state_reg.ab_mask <= `MLA_MASK_RESET;
            state_reg.bc_mask <= `MLA_MASK_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_mask_blocks;
        @(posedge clk) disable iff (!arst_n)
        (sel_ab_cells && state_reg.ab_mask[0]) |-> !load_vec[0];
    endproperty
    a_mask_blocks: assert property (p_mask_blocks) // see RQ15
        else $error("masked cell was loaded");

    property p_edge_load;
        @(posedge clk) disable iff (!arst_n)
        (!level_load && sel_ab_cells && !state_reg.ab_mask[3] &&
         state_reg.wr_d && !wr_strobe) |=> (cell_q[3] == $past(host_wdata[3]));
    endproperty
    a_edge_load: assert property (p_edge_load) // see RQ14
        else $error("edge load missed");

    property p_level_load;
        @(posedge clk) disable iff (!arst_n)
        (level_load && wr_strobe && sel_bc_cells && !state_reg.bc_mask[5])
        |=> (cell_q[13] == $past(host_wdata[5]));
    endproperty
    a_level_load: assert property (p_level_load) // see RQ13
        else $error("level load wrong bit");

    property p_oe;
        @(posedge clk) disable iff (!arst_n)
        (pin_dir[4] || pt_oe[4] || no_oe_eqn[4]) |-> pin_oe[4];
    endproperty
    a_oe: assert property (p_oe) // see RQ17
        else $error("pin enable missing");

    property p_read_out;
        @(posedge clk) disable iff (!arst_n)
        sel_ab_cells |=> (host_rdata == $past(cell_q[7:0]));
    endproperty
    a_read_out: assert property (p_read_out) // see RQ16
        else $error("output cell read wrong");

    property p_mask_write;
        @(posedge clk) disable iff (!arst_n)
        (state_reg.wr_d && !wr_strobe && sel_bc_mask)
        |=> (state_reg.bc_mask == $past(host_wdata));
    endproperty
    a_mask_write: assert property (p_mask_write) // see RQ15
        else $error("mask not written");

    property p_feedback;
        @(posedge clk) disable iff (!arst_n)
        cell_feedback == cell_out;
    endproperty
    a_feedback: assert property (p_feedback) // see RQ8
        else $error("feedback differs from pin output");

    property p_cs;
        @(posedge clk) disable iff (!arst_n)
        ext_cs == cs_terms;
    endproperty
    a_cs: assert property (p_cs) // see RQ1
        else $error("chip select mismatch");
endmodule

`default_nettype wire
